//--- rtl/cpu_mode_address_control.sv
// mode-dependent address, vector, stack and timing control
`timescale 1ns/10ps
module cpu_mode_address_control
   import mode_addr_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [1:0] mode_pins,
   input wire logic [31:0] ea_in,
   input wire logic is_data_access,
   input wire logic in_branch_instr,
   input wire logic [7:0] vector_num,
   input wire logic [7:0] indirect_abs_addr,
   input wire logic [31:0] indirect_operand,
   input wire logic [31:0] vector_entry,
   input wire logic [31:0] pc_in,
   input wire logic instr_fetch_width_select,
   input wire logic [15:0] upper_half_in,
   input wire logic incdec_carry,
   input wire logic [7:0] condition_code_reg_in,
   input wire logic exception_start,
   input wire logic op_start,
   input wire logic [3:0] op_kind,
   input wire logic sleep_exec,
   input wire logic wake,
   output logic [3:0] cpu_mode,
   output logic [31:0] ea_out,
   output logic ea_out_of_range,
   output logic [31:0] vector_addr,
   output logic [31:0] vector_target,
   output logic [31:0] indirect_addr,
   output logic [31:0] indirect_target,
   output logic [5:0] stack_pc_width,
   output logic stack_exr,
   output logic [31:0] stacked_pc,
   output logic [31:0] fetch_addr,
   output logic [5:0] fetch_width,
   output logic [15:0] upper_half_out,
   output logic upper_half_free,
   output logic [7:0] condition_code_reg_out,
   output logic [2:0] stack_reg_index,
   output logic op_busy,
   output logic op_done,
   output logic power_down
);
   cpu_mode_t mode_q;
   logic sampled_q;
   logic [4:0] op_cnt_q;
   logic [4:0] op_cnt_d;
   logic pd_q;

   function automatic logic [4:0] op_states(input logic [3:0] k);
      case (k)
         OP_MUL32: op_states = STATES_MUL32;
         OP_DIV16: op_states = STATES_DIV16;
         OP_DIV32: op_states = STATES_DIV32;
         default: op_states = STATES_ONE;
      endcase
   endfunction

   function automatic logic [31:0] trunc_addr(input logic [31:0] a,
         input cpu_mode_t m);
      case (m)
         MODE_NORMAL: trunc_addr = a & MASK16;
         MODE_MIDDLE: trunc_addr = {{16{a[SIGN16]}}, a[15:0]} & MASK24;
         default: trunc_addr = a;
      endcase
   endfunction

   // mode latched once after reset release
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mode_q <= MODE_NORMAL;
         sampled_q <= 1'b0;
      end else if (!sampled_q) begin
         sampled_q <= 1'b1;
         case (mode_pins)
            PIN_MIDDLE: mode_q <= MODE_MIDDLE;
            PIN_ADVANCED: mode_q <= MODE_ADVANCED;
            PIN_MAXIMUM: mode_q <= MODE_MAXIMUM;
            default: mode_q <= MODE_NORMAL;
         endcase
      end
   end
   assign cpu_mode = mode_q;

   // effective address and range checks
   always_comb begin
      ea_out = trunc_addr(ea_in, mode_q);
      ea_out_of_range = 1'b0;
      case (mode_q)
         MODE_MIDDLE: ea_out_of_range = is_data_access &&
            ((ea_in & ~MASK16) != 32'h0);
         MODE_ADVANCED: ea_out_of_range = !is_data_access &&
            ((ea_in & ~MASK24) != 32'h0);
         default: ea_out_of_range = 1'b0;
      endcase
   end

   // vector table and memory-indirect targets
   always_comb begin
      indirect_addr = trunc_addr({24'h0, indirect_abs_addr}, mode_q);
      case (mode_q)
         MODE_NORMAL: begin
            vector_addr = VEC_BASE + {23'h0, vector_num, 1'b0};
            vector_target = vector_entry & MASK16;
            indirect_target = indirect_operand & MASK16;
            stack_pc_width = STACK_W16;
            stack_exr = 1'b0;
         end
         MODE_MAXIMUM: begin
            vector_addr = VEC_BASE + {22'h0, vector_num, 2'h0};
            vector_target = vector_entry;
            indirect_target = indirect_operand;
            stack_pc_width = STACK_W32;
            stack_exr = 1'b1;
         end
         default: begin
            vector_addr = VEC_BASE + {22'h0, vector_num, 2'h0};
            vector_target = vector_entry & MASK24;
            indirect_target = indirect_operand & MASK24;
            stack_pc_width = STACK_W24;
            stack_exr = 1'b0;
         end
      endcase
   end

   always_comb begin
      case (mode_q)
         MODE_NORMAL: stacked_pc = pc_in & MASK16;
         MODE_MAXIMUM: stacked_pc = pc_in;
         default: stacked_pc = pc_in & MASK24;
      endcase
   end

   assign fetch_addr = pc_in & PC_ALIGN;
   assign fetch_width = instr_fetch_width_select ? FETCH_W32 : FETCH_W16;
   assign stack_reg_index = 3'(SP_REG_INDEX);

   // upper half register behaviour
   always_comb begin
      upper_half_out = upper_half_in;
      if (incdec_carry && (mode_q == MODE_NORMAL || mode_q == MODE_MIDDLE))
         upper_half_out = upper_half_in + 16'h0001;
      upper_half_free = !(mode_q == MODE_MIDDLE && in_branch_instr);
   end

   always_comb begin
      condition_code_reg_out = condition_code_reg_in;
      if (exception_start)
         condition_code_reg_out[IMASK_BIT] = 1'b1;
   end

   // execution timing counter
   always_comb begin
      op_cnt_d = op_cnt_q;
      if (op_cnt_q != 5'h0)
         op_cnt_d = op_cnt_q - 5'h01;
      else if (op_start)
         op_cnt_d = op_states(op_kind) - 5'h01;
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         op_cnt_q <= 5'h0;
      else
         op_cnt_q <= op_cnt_d;
   end
   assign op_busy = (op_cnt_q != 5'h0);
   assign op_done = (op_cnt_q == 5'h01) ||
      (op_cnt_q == 5'h0 && op_start && op_states(op_kind) == STATES_ONE);

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         pd_q <= 1'b0;
      else if (sleep_exec)
         pd_q <= 1'b1;
      else if (wake)
         pd_q <= 1'b0;
   end
   assign power_down = pd_q;

   AST_MODE_HELD: assert property (@(posedge clk) disable iff (reset)
      sampled_q && $past(sampled_q) |-> $stable(mode_q))
      else $error("mode changed after sampling");
   AST_NORMAL_EA: assert property (@(posedge clk) disable iff (reset)
      mode_q == MODE_NORMAL |-> ea_out[31:16] == 16'h0)
      else $error("normal ea not truncated");
   AST_MIDDLE_SIGN: assert property (@(posedge clk) disable iff (reset)
      mode_q == MODE_MIDDLE |-> ea_out[23:16] == {8{ea_in[15]}})
      else $error("middle ea not sign extended");
   AST_MUL32: assert property (@(posedge clk) disable iff (reset)
      op_start && !op_busy && op_kind == OP_MUL32 |->
      ##1 op_busy [*4] ##0 op_done)
      else $error("mul32 not five states");
   AST_DIV16: assert property (@(posedge clk) disable iff (reset)
      op_start && !op_busy && op_kind == OP_DIV16 |->
      ##9 op_done)
      else $error("div16 not ten states");
   AST_DIV32: assert property (@(posedge clk) disable iff (reset)
      op_start && !op_busy && op_kind == OP_DIV32 |->
      ##17 op_done)
      else $error("div32 not eighteen states");
   AST_ONE_STATE: assert property (@(posedge clk) disable iff (reset)
      op_start && !op_busy && op_kind == OP_ADDSUB |->
      op_done ##1 !op_busy)
      else $error("add not one state");
   AST_STACK_W: assert property (@(posedge clk) disable iff (reset)
      stack_pc_width == ((mode_q == MODE_NORMAL) ? STACK_W16 :
      (mode_q == MODE_MAXIMUM) ? STACK_W32 : STACK_W24))
      else $error("stack width wrong");
   AST_FETCH_ALIGN: assert property (@(posedge clk) disable iff (reset)
      !fetch_addr[0] && fetch_addr[31:1] == pc_in[31:1])
      else $error("fetch address misaligned");
   AST_SLEEP: assert property (@(posedge clk) disable iff (reset)
      sleep_exec |=> power_down)
      else $error("sleep did not power down");
   AST_IMASK: assert property (@(posedge clk) disable iff (reset)
      exception_start |-> condition_code_reg_out[IMASK_BIT])
      else $error("interrupt mask not set");
   AST_WIDE_VEC: assert property (@(posedge clk) disable iff (reset)
      mode_q inside {MODE_MIDDLE, MODE_ADVANCED} |->
      vector_target[31:24] == 8'h0 && indirect_target[31:24] == 8'h0)
      else $error("wide vector top byte not zero");
   AST_MUL16: assert property (@(posedge clk) disable iff (reset)
      op_start && !op_busy && op_kind == OP_MUL16 |->
      op_done ##1 !op_busy)
      else $error("mul16 not one state");
   AST_BUSY_COUNT: assert property (@(posedge clk) disable iff (reset)
      op_busy |=> op_cnt_q == $past(op_cnt_q) - 5'h01)
      else $error("busy counter skipped or restarted");
   AST_WAKE: assert property (@(posedge clk) disable iff (reset)
      wake && !sleep_exec |=> !power_down)
      else $error("wake did not leave power-down");
   AST_MODE_ONEHOT: assert property (@(posedge clk) disable iff (reset)
      $onehot(mode_q))
      else $error("mode not one of four");
   AST_RANGE_MIDDLE: assert property (@(posedge clk) disable iff (reset)
      mode_q == MODE_MIDDLE && is_data_access |->
      ea_out_of_range == (ea_in[31:16] != 16'h0))
      else $error("middle data range flag wrong");
   AST_RANGE_ADV: assert property (@(posedge clk) disable iff (reset)
      mode_q == MODE_ADVANCED && !is_data_access |->
      ea_out_of_range == (ea_in[31:24] != 8'h0))
      else $error("advanced program range flag wrong");
   AST_NORMAL_VEC: assert property (@(posedge clk) disable iff (reset)
      mode_q == MODE_NORMAL |-> vector_addr[31:9] == 23'h0 &&
      !vector_addr[0] && vector_target[31:16] == 16'h0)
      else $error("normal vector entry not 16 bits");
   AST_MAX_VEC: assert property (@(posedge clk) disable iff (reset)
      mode_q == MODE_MAXIMUM |-> vector_target == vector_entry &&
      vector_addr[1:0] == 2'h0)
      else $error("maximum vector not full 32 bits");
   AST_MAX_INDIRECT: assert property (@(posedge clk) disable iff (reset)
      mode_q == MODE_MAXIMUM |-> indirect_target == indirect_operand)
      else $error("maximum indirect target not full 32 bits");
   AST_INDIRECT_ADDR: assert property (@(posedge clk) disable iff (reset)
      indirect_addr[31:8] == 24'h0 &&
      indirect_addr[7:0] == indirect_abs_addr)
      else $error("indirect address not from 8-bit field");
   AST_STACK_NORMAL: assert property (@(posedge clk) disable iff (reset)
      mode_q == MODE_NORMAL |-> stacked_pc[31:16] == 16'h0 &&
      stacked_pc[15:0] == pc_in[15:0])
      else $error("normal stacked pc not 16 bits");
   AST_STACK_WIDE: assert property (@(posedge clk) disable iff (reset)
      mode_q inside {MODE_MIDDLE, MODE_ADVANCED} |->
      stacked_pc == {8'h0, pc_in[23:0]})
      else $error("wide stacked pc not 24 bits");
   AST_EXR_MAX: assert property (@(posedge clk) disable iff (reset)
      stack_exr == (mode_q == MODE_MAXIMUM))
      else $error("extended control stacking wrong");
   AST_FETCH_W: assert property (@(posedge clk) disable iff (reset)
      fetch_width == (instr_fetch_width_select ? FETCH_W32 :
      FETCH_W16))
      else $error("fetch width not from select");
   AST_SP_INDEX: assert property (@(posedge clk) disable iff (reset)
      stack_reg_index == 3'(SP_REG_INDEX))
      else $error("stack pointer not register seven");
   AST_UPPER_KEEP: assert property (@(posedge clk) disable iff (reset)
      !incdec_carry |-> upper_half_out == upper_half_in)
      else $error("upper half changed without carry");
   AST_UPPER_FREE: assert property (@(posedge clk) disable iff (reset)
      mode_q == MODE_MIDDLE && in_branch_instr |-> !upper_half_free)
      else $error("upper half free inside middle branch");
endmodule

//--- rtl/mode_addr_pkg.sv
// constants for the mode-dependent address control block
package mode_addr_pkg;
   typedef enum logic [3:0] {
      MODE_NORMAL = 4'h1,
      MODE_MIDDLE = 4'h2,
      MODE_ADVANCED = 4'h4,
      MODE_MAXIMUM = 4'h8
   } cpu_mode_t;
   localparam logic [1:0] PIN_NORMAL = 2'h0;
   localparam logic [1:0] PIN_MIDDLE = 2'h1;
   localparam logic [1:0] PIN_ADVANCED = 2'h2;
   localparam logic [1:0] PIN_MAXIMUM = 2'h3;
   localparam logic [31:0] VEC_BASE = 32'h0000_0000;
   localparam logic [31:0] VEC_STRIDE_NARROW = 32'h0000_0002;
   localparam logic [31:0] VEC_STRIDE_WIDE = 32'h0000_0004;
   localparam logic [31:0] MASK16 = 32'h0000_ffff;
   localparam logic [31:0] MASK24 = 32'h00ff_ffff;
   localparam logic [31:0] PC_ALIGN = 32'hffff_fffe;
   localparam int SIGN16 = 15;
   localparam logic [5:0] STACK_W16 = 6'h10;
   localparam logic [5:0] STACK_W24 = 6'h18;
   localparam logic [5:0] STACK_W32 = 6'h20;
   localparam logic [5:0] FETCH_W16 = 6'h10;
   localparam logic [5:0] FETCH_W32 = 6'h20;
   localparam int SP_REG_INDEX = 7;
   localparam int IMASK_BIT = 7;
   typedef enum logic [3:0] {
      OP_ADDSUB = 4'h0,
      OP_MUL16 = 4'h1,
      OP_MUL32 = 4'h2,
      OP_DIV16 = 4'h3,
      OP_DIV32 = 4'h4
   } alu_op_t;
   localparam logic [4:0] STATES_ONE = 5'h01;
   localparam logic [4:0] STATES_MUL32 = 5'h05;
   localparam logic [4:0] STATES_DIV16 = 5'h0a;
   localparam logic [4:0] STATES_DIV32 = 5'h12;
endpackage

//--- verif/mem_model.sv
// program and data memory answering vector and indirect operand reads
`timescale 1ns/10ps
module mem_model (
   input wire logic [31:0] vector_addr,
   input wire logic [31:0] indirect_addr,
   output logic [31:0] vector_entry,
   output logic [31:0] indirect_operand
);
   // each word differs, but the top byte can still be zero, as for address 608
   function automatic logic [31:0] word_at(input logic [31:0] a);
      return (a * 32'h9e37_79b9) ^ 32'hc3a5_5a3c;
   endfunction
   assign vector_entry = word_at(vector_addr);
   assign indirect_operand = word_at(indirect_addr);
endmodule

//--- verif/tb_top.sv
// self-checking bench for the mode-dependent address control block
`timescale 1ns/10ps
module tb_top;
   import mode_addr_pkg::*;
   logic clk = 0, reset = 1, is_data_access = 0, in_branch_instr = 0;
   logic instr_fetch_width_select = 0, incdec_carry = 0;
   logic exception_start = 0, op_start = 0, sleep_exec = 0, wake = 0;
   logic [1:0] mode_pins = 0;
   logic [31:0] ea_in = 0, pc_in = 0, indirect_operand, vector_entry;
   logic [7:0] vector_num = 0, indirect_abs_addr = 0;
   logic [7:0] condition_code_reg_in = 0, condition_code_reg_out;
   logic [15:0] upper_half_in = 0, upper_half_out;
   logic [3:0] op_kind = 0, cpu_mode;
   logic [31:0] ea_out, vector_addr, vector_target, indirect_addr;
   logic [31:0] indirect_target, stacked_pc, fetch_addr, msk, eexp;
   logic [5:0] stack_pc_width, fetch_width;
   logic stack_exr, upper_half_free, op_busy, op_done, power_down;
   logic [2:0] stack_reg_index;
   logic ea_out_of_range;
   int errors = 0, samples_checked = 0;
   int lat[5] = '{1, 1, 5, 10, 18};
   always #5 clk = ~clk;
   cpu_mode_address_control cpu_mode_address_control_inst (
      .clk, .reset, .mode_pins, .ea_in, .is_data_access, .in_branch_instr,
      .vector_num, .indirect_abs_addr, .indirect_operand, .vector_entry,
      .pc_in, .instr_fetch_width_select, .upper_half_in, .incdec_carry,
      .condition_code_reg_in, .exception_start, .op_start, .op_kind,
      .sleep_exec, .wake, .cpu_mode, .ea_out, .ea_out_of_range,
      .vector_addr, .vector_target, .indirect_addr, .indirect_target,
      .stack_pc_width, .stack_exr, .stacked_pc, .fetch_addr, .fetch_width,
      .upper_half_out, .upper_half_free, .condition_code_reg_out,
      .stack_reg_index, .op_busy, .op_done, .power_down);
   mem_model mem_model_inst (.vector_addr, .indirect_addr, .vector_entry,
      .indirect_operand);
   function automatic logic [31:0] word_at(input logic [31:0] a);
      return (a * 32'h9e37_79b9) ^ 32'hc3a5_5a3c;
   endfunction
   task automatic check(input string nm, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wrap_up;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // pins move away after sampling; the mode must not follow them
   task automatic do_reset(input logic [1:0] p);
      reset = 1;
      exception_start = 0;
      mode_pins = p;
      repeat (2) @(negedge clk);
      reset = 0;
      repeat (2) @(negedge clk);
      mode_pins = ~p;
      @(negedge clk);
   endtask
   // a second request is poked while busy and must be ignored
   task automatic run_op(input logic [3:0] kind, input int n, input bit poke);
      int k;
      @(negedge clk);
      op_start = 1;
      op_kind = kind;
      k = 0;
      #1;
      while (op_done !== 1'b1 && k < 40) begin
         @(negedge clk);
         op_start = poke && k == 1;
         op_kind = (poke && k == 1) ? OP_DIV32 : kind;
         #1;
         k++;
      end
      check("op_latency", k, n - 1);
      check("op_busy", {31'h0, op_busy}, {31'h0, n > 1});
      @(negedge clk);
      op_start = 0;
   endtask
   initial begin
      #20000;
      errors++;
      wrap_up();
   end
   initial begin
      void'($urandom(32'h754bf4f6));
      for (int m = 0; m < 4; m++) begin
         do_reset(m[1:0]);
         check("cpu_mode", {28'h0, cpu_mode}, 32'h1 << m);
         msk = m == 0 ? MASK16 : (m == 3 ? 32'hffff_ffff : MASK24);
         repeat (6) begin
            @(negedge clk);
            ea_in = $urandom;
            pc_in = $urandom;
            {vector_num, indirect_abs_addr, upper_half_in} = $urandom;
            {condition_code_reg_in, incdec_carry, in_branch_instr,
               exception_start, is_data_access} = 12'($urandom);
            instr_fetch_width_select = 1'($urandom);
            #1;
            eexp = m == 0 ? ea_in & MASK16 : (m == 1 ?
               {8'h0, {8{ea_in[15]}}, ea_in[15:0]} : ea_in);
            check("ea_out", ea_out, eexp);
            check("ea_range", {31'h0, ea_out_of_range},
               {31'h0, (m == 1 && is_data_access && ea_in[31:16] != 0) ||
               (m == 2 && !is_data_access && ea_in[31:24] != 0)});
            eexp = {24'h0, vector_num} << (m == 0 ? 1 : 2);
            check("vector_addr", vector_addr, eexp);
            check("vector_tgt", vector_target, word_at(eexp) & msk);
            eexp = {24'h0, indirect_abs_addr};
            check("indirect_addr", indirect_addr, eexp);
            check("indirect_tgt", indirect_target, word_at(eexp) & msk);
            check("stack_w", {26'h0, stack_pc_width},
               m == 0 ? 32'h10 : (m == 3 ? 32'h20 : 32'h18));
            check("stack_exr", {31'h0, stack_exr}, m == 3);
            check("stacked_pc", stacked_pc, pc_in & msk);
            check("fetch_addr", fetch_addr, pc_in & PC_ALIGN);
            check("fetch_w", {26'h0, fetch_width},
               instr_fetch_width_select ? 32'h20 : 32'h10);
            check("upper_half", {16'h0, upper_half_out}, upper_half_in +
               16'(m < 2 && incdec_carry));
            check("upper_free", {31'h0, upper_half_free},
               !(m == 1 && in_branch_instr));
            check("ccr", {24'h0, condition_code_reg_out},
               condition_code_reg_in | {exception_start, 7'h0});
            check("sp_index", {29'h0, stack_reg_index}, 32'h7);
         end
      end
      exception_start = 0;
      for (int i = 0; i < 5; i++) begin
         run_op(i[3:0], lat[i], i == 2);
      end
      @(negedge clk);
      sleep_exec = 1;
      @(negedge clk);
      sleep_exec = 0;
      check("power_down", {31'h0, power_down}, 32'h1);
      repeat (3) @(negedge clk);
      wake = 1;
      sleep_exec = 1;
      @(negedge clk);
      sleep_exec = 0;
      check("power_down", {31'h0, power_down}, 32'h1);
      @(negedge clk);
      wake = 0;
      check("power_down", {31'h0, power_down}, 32'h0);
      wrap_up();
   end
endmodule
